// ### prf_pkg.sv
// Shared constants, types and field layouts of the purge reply and error framer.
package prf_pkg;

  // ****************************************************************
  // Buffer geometry
  // ****************************************************************
  localparam int unsigned RAM_AW = 8;
  localparam int unsigned RAM_DW = 8;
  localparam logic [15:0] RAM_DEPTH = 16'h0100;

  // ****************************************************************
  // Operation type codes and error codes
  // ****************************************************************
  localparam logic [7:0] OPT_PURGE_REQ = 8'h05;
  localparam logic [7:0] OPT_PURGE_REPLY = 8'h06;
  localparam logic [7:0] OPT_ERR_IND = 8'h88;
  localparam logic [15:0] ERR_AUTH_FAIL = 16'h000B;

  // ****************************************************************
  // Octet offsets of the fixed and mandatory common header
  // ****************************************************************
  localparam logic [7:0] OFS_AFN = 8'h00;
  localparam logic [7:0] OFS_PRO_TYPE = 8'h02;
  localparam logic [7:0] OFS_SNAP = 8'h04;
  localparam logic [7:0] OFS_HOP = 8'h09;
  localparam logic [7:0] OFS_PKTSZ = 8'h0A;
  localparam logic [7:0] OFS_CSUM = 8'h0C;
  localparam logic [7:0] OFS_EXTOFF = 8'h0E;
  localparam logic [7:0] OFS_OP_VER = 8'h10;
  localparam logic [7:0] OFS_OP_TYPE = 8'h11;
  localparam logic [7:0] OFS_SHTL = 8'h12;
  localparam logic [7:0] OFS_SSTL = 8'h13;
  localparam logic [7:0] OFS_SRC_PLEN = 8'h14;
  localparam logic [7:0] OFS_DST_PLEN = 8'h15;
  localparam logic [7:0] OFS_FLAGS = 8'h16;
  localparam logic [7:0] OFS_REQ_ID = 8'h18;
  localparam logic [7:0] OFS_NBMA = 8'h1C;
  localparam int unsigned NO_REPLY_BIT = 7;

  // ****************************************************************
  // Address lengths and reset values
  // ****************************************************************
  localparam logic [7:0] ATM_ADDR_LEN = 8'h14;
  localparam logic [7:0] PROTO_ADDR_LEN = 8'h04;
  localparam logic [5:0] ADDR_LEN_MASK = 6'h3F;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [31:0] ADDR_RST = 32'h00000000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    PRF_KIND_FWD,
    PRF_KIND_REPLY,
    PRF_KIND_ERR
  } prf_kind_e;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } prf_byte_s;

  typedef struct packed {
    logic valid;
    logic last;
    prf_kind_e kind;
    logic [7:0] data;
  } prf_tx_s;

  typedef struct packed {
    logic [15:0] afn;
    logic [15:0] pro_type;
    logic [39:0] snap;
    logic [7:0] hop;
    logic [7:0] op_version;
    logic [159:0] atm_addr;
    logic sub_en;
    logic [159:0] sub_addr;
    logic src_proto_en;
    logic [31:0] src_proto;
  } prf_cfg_s;

  typedef struct packed {
    logic [15:0] code;
    logic [15:0] offset;
    logic [7:0] dst_len;
    logic [31:0] dst_addr;
    logic [15:0] csum;
  } prf_err_s;

endpackage

// ### prf_pkt_ram.sv
// Packet store holding one received packet until its fate is known.
`timescale 1ns/1ps
module prf_pkt_ram (
  // Clock, reset and enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Write port
  input wire logic i_we,
  input wire logic [prf_pkg::RAM_AW-1:0] i_waddr,
  input wire logic [prf_pkg::RAM_DW-1:0] i_wdata,
  // Read port
  input wire logic [prf_pkg::RAM_AW-1:0] i_raddr,
  output logic [prf_pkg::RAM_DW-1:0] o_rdata
);
  import prf_pkg::*;

  logic [RAM_DW-1:0] mem [0:(1<<RAM_AW)-1];

  always_ff @(posedge i_sys_clk) begin
    if (i_ce && i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= BYTE_RST;
    end else if (i_ce) begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule

// ### prf_err_gen.sv
// Byte generator for the error indication message, one octet per index.
`timescale 1ns/1ps
module prf_err_gen (
  // Clock, reset and enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Byte request and message content
  input wire logic [7:0] i_idx,
  input wire prf_pkg::prf_cfg_s i_cfg,
  input wire prf_pkg::prf_err_s i_err,
  // Answer
  output logic [7:0] o_byte,
  output logic [7:0] o_len
);
  import prf_pkg::*;

  logic [7:0] sub_len;
  logic [7:0] src_len;
  logic [7:0] ofs_sub;
  logic [7:0] ofs_src;
  logic [7:0] ofs_dst;
  logic [7:0] hdr_byte;
  logic [7:0] next_byte;

  function automatic logic [7:0] pick(input logic [159:0] vec,
                                      input logic [7:0] k);
    pick = vec[159 - 8 * k -: 8];
  endfunction

  // ****************************************************************
  // Layout
  // ****************************************************************
  assign sub_len = i_cfg.sub_en ? ATM_ADDR_LEN : 8'h00;
  assign src_len = i_cfg.src_proto_en ? PROTO_ADDR_LEN : 8'h00;
  assign ofs_sub = OFS_NBMA + ATM_ADDR_LEN;
  assign ofs_src = ofs_sub + sub_len;
  assign ofs_dst = ofs_src + src_len;
  // The message ends after the last address; nothing follows.
  assign o_len = ofs_dst + i_err.dst_len;

  // ****************************************************************
  // Header octets
  // ****************************************************************
  always_comb begin
    hdr_byte = 8'h00;
    case (i_idx)
      OFS_AFN: hdr_byte = i_cfg.afn[15:8];
      OFS_AFN + 8'h01: hdr_byte = i_cfg.afn[7:0];
      OFS_PRO_TYPE: hdr_byte = i_cfg.pro_type[15:8];
      OFS_PRO_TYPE + 8'h01: hdr_byte = i_cfg.pro_type[7:0];
      OFS_SNAP: hdr_byte = i_cfg.snap[39:32];
      OFS_SNAP + 8'h01: hdr_byte = i_cfg.snap[31:24];
      OFS_SNAP + 8'h02: hdr_byte = i_cfg.snap[23:16];
      OFS_SNAP + 8'h03: hdr_byte = i_cfg.snap[15:8];
      OFS_SNAP + 8'h04: hdr_byte = i_cfg.snap[7:0];
      OFS_HOP: hdr_byte = i_cfg.hop;
      OFS_PKTSZ + 8'h01: hdr_byte = o_len;
      OFS_CSUM: hdr_byte = i_err.csum[15:8];
      OFS_CSUM + 8'h01: hdr_byte = i_err.csum[7:0];
      // Extension offset stays zero: no extension is ever appended.
      OFS_EXTOFF: hdr_byte = 8'h00;
      OFS_OP_VER: hdr_byte = i_cfg.op_version;
      OFS_OP_TYPE: hdr_byte = OPT_ERR_IND;
      OFS_SHTL: hdr_byte = ATM_ADDR_LEN;
      OFS_SSTL: hdr_byte = sub_len;
      OFS_SRC_PLEN: hdr_byte = src_len;
      OFS_DST_PLEN: hdr_byte = i_err.dst_len;
      // Flags are unused and sent as zero.
      OFS_FLAGS: hdr_byte = 8'h00;
      OFS_REQ_ID: hdr_byte = i_err.code[15:8];
      OFS_REQ_ID + 8'h01: hdr_byte = i_err.code[7:0];
      OFS_REQ_ID + 8'h02: hdr_byte = i_err.offset[15:8];
      OFS_REQ_ID + 8'h03: hdr_byte = i_err.offset[7:0];
      default: hdr_byte = 8'h00;
    endcase
  end

  // ****************************************************************
  // Address octets and output register
  // ****************************************************************
  always_comb begin
    next_byte = 8'h00;
    if (i_idx < OFS_NBMA) begin
      next_byte = hdr_byte;
    end else if (i_idx < ofs_sub) begin
      next_byte = pick(i_cfg.atm_addr, i_idx - OFS_NBMA);
    end else if (i_idx < ofs_src) begin
      next_byte = pick(i_cfg.sub_addr, i_idx - ofs_sub);
    end else if (i_idx < ofs_dst) begin
      next_byte = pick({i_cfg.src_proto, 128'h0}, i_idx - ofs_src);
    end else if (i_idx < o_len) begin
      next_byte = pick({i_err.dst_addr, 128'h0}, i_idx - ofs_dst);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_byte <= BYTE_RST;
    end else if (i_ce) begin
      o_byte <= next_byte;
    end
  end

endmodule

// ### prf_framer.sv
// Purge reply and error indication framer for control messages over ATM.
`timescale 1ns/1ps
// What this block does
// - Reply is the request with type changed
// - Reply operation type is 0x06
// - No-reply flag decides whether reply goes out
// - Reply copies the whole common header
// - Reply copies every client information element
// - Reply copies every extension
// - Error indication operation type is 0x88
// - Flags ignored; request id holds code, offset
// - Source NBMA is own ATM address, subaddress
// - Optional source protocol address, else length zero
// - Optional destination address names faulty sender
// - Only code 0x000B, authentication failure, generated
// - Offset counts octets from fixed header start
// - Never answer an error indication with one
// - Drop the faulty packet when indicating error
// - At most one error indication per packet
// - Error indication carries no client elements
// - Error indication carries no extensions
// - Purge request recognised by type 0x05
module prf_framer (
  // Clock, reset and enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Received packet stream
  input wire prf_pkg::prf_byte_s i_rx,
  input wire logic i_fault,
  output logic o_rx_ready,
  // Identity of this component
  input wire prf_pkg::prf_cfg_s i_cfg,
  // Outgoing message stream
  output prf_pkg::prf_tx_s o_tx,
  input wire logic i_tx_ready,
  // Events
  output logic o_purge,
  output logic o_drop
);
  import prf_pkg::*;

  typedef enum logic [2:0] {
    S_RECV,
    S_DECIDE,
    S_SUM_FETCH,
    S_SUM_ADD,
    S_FETCH,
    S_LOAD,
    S_HOLD
  } prf_state_e;

  prf_state_e state;
  prf_state_e next_state;
  prf_kind_e kind;
  prf_kind_e next_kind;
  logic [15:0] rx_cnt;
  logic [15:0] pkt_len;
  logic [7:0] op_type;
  logic no_reply;
  logic [5:0] shtl_len;
  logic [5:0] sstl_len;
  logic [7:0] src_plen;
  logic fault_seen;
  logic [15:0] fault_ofs;
  logic [7:0] dst_byte [0:3];
  logic [31:0] dst_addr;
  logic [7:0] idx;
  logic [15:0] acc;
  logic [15:0] csum;
  logic [7:0] ram_q;
  logic [7:0] gen_q;
  logic [7:0] gen_len;
  prf_err_s err;

  // ****************************************************************
  // Receive decode
  // ****************************************************************
  logic rx_take;
  logic rx_end;
  logic rx_fits;
  logic [15:0] dst_start;
  logic [15:0] dst_k;
  logic dst_hit;
  logic fault_set;
  logic back_to_recv;

  assign o_rx_ready = (state == S_RECV);
  assign rx_take = i_rx.valid & o_rx_ready;
  assign rx_end = rx_take & i_rx.last;
  assign rx_fits = (rx_cnt < RAM_DEPTH);
  assign dst_start = 16'(OFS_NBMA) + 16'(shtl_len) + 16'(sstl_len);
  assign dst_k = rx_cnt - dst_start;
  assign dst_hit = rx_take & (rx_cnt >= dst_start) &
                   (dst_k < 16'(PROTO_ADDR_LEN));
  assign fault_set = rx_take & i_fault & ~fault_seen;
  assign back_to_recv = (next_state == S_RECV) & (state != S_RECV);

  // ****************************************************************
  // Decision on a complete packet
  // ****************************************************************
  logic too_long;
  logic is_err_in;
  logic is_purge;
  logic dec_gen_err;
  logic dec_reply;
  logic dec_fwd;

  assign too_long = (pkt_len > RAM_DEPTH);
  assign is_err_in = (op_type == OPT_ERR_IND);
  assign is_purge = (op_type == OPT_PURGE_REQ) & ~fault_seen;
  assign dec_gen_err = fault_seen & ~is_err_in;
  // The sender usually asks for no reply; only a clear flag answers.
  assign dec_reply = is_purge & ~no_reply & ~too_long;
  assign dec_fwd = ~fault_seen & ~too_long & ~is_purge;

  // ****************************************************************
  // Output sequencing
  // ****************************************************************
  logic [7:0] last_idx;
  logic is_last;
  logic [15:0] word;
  logic [16:0] sum_tmp;
  logic [15:0] next_acc;
  logic [7:0] load_byte;

  assign last_idx = (kind == PRF_KIND_ERR) ? gen_len - 8'h01 :
                    8'(pkt_len - 16'h0001);
  assign is_last = (idx == last_idx);
  assign word = idx[0] ? {8'h00, gen_q} : {gen_q, 8'h00};
  assign sum_tmp = {1'b0, acc} + {1'b0, word};
  assign next_acc = sum_tmp[15:0] + {15'h0000, sum_tmp[16]};
  // Every octet but the type is copied from the stored request.
  // This covers its elements and its extensions alike.
  assign load_byte = (kind == PRF_KIND_ERR) ? gen_q :
                     (kind == PRF_KIND_REPLY && idx == OFS_OP_TYPE) ?
                     OPT_PURGE_REPLY : ram_q;
  assign next_kind = dec_gen_err ? PRF_KIND_ERR :
                     dec_reply ? PRF_KIND_REPLY : PRF_KIND_FWD;

  always_comb begin
    next_state = state;
    case (state)
      S_RECV: begin
        if (rx_end) begin
          next_state = S_DECIDE;
        end
      end
      S_DECIDE: begin
        if (dec_gen_err) begin
          next_state = S_SUM_FETCH;
        end else if (dec_reply || dec_fwd) begin
          next_state = S_FETCH;
        end else begin
          next_state = S_RECV;
        end
      end
      S_SUM_FETCH: next_state = S_SUM_ADD;
      S_SUM_ADD: next_state = is_last ? S_FETCH : S_SUM_FETCH;
      S_FETCH: next_state = S_LOAD;
      S_LOAD: next_state = S_HOLD;
      S_HOLD: begin
        if (i_tx_ready) begin
          next_state = is_last ? S_RECV : S_FETCH;
        end
      end
      default: next_state = S_RECV;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= S_RECV;
      kind <= PRF_KIND_FWD;
    end else if (i_ce) begin
      state <= next_state;
      if (state == S_DECIDE) begin
        kind <= next_kind;
      end
    end
  end

  // ****************************************************************
  // Receive counters and captured fields
  // ****************************************************************
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_cnt <= WORD_RST;
      pkt_len <= WORD_RST;
    end else if (i_ce) begin
      if (back_to_recv) begin
        rx_cnt <= WORD_RST;
      end else if (rx_take) begin
        rx_cnt <= rx_cnt + 16'h0001;
      end
      if (rx_end) begin
        pkt_len <= rx_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      op_type <= BYTE_RST;
      no_reply <= 1'b0;
      shtl_len <= 6'h00;
      sstl_len <= 6'h00;
      src_plen <= BYTE_RST;
    end else if (i_ce) begin
      if (back_to_recv) begin
        op_type <= BYTE_RST;
        no_reply <= 1'b0;
        shtl_len <= 6'h00;
        sstl_len <= 6'h00;
        src_plen <= BYTE_RST;
      end else if (rx_take) begin
        if (rx_cnt == 16'(OFS_OP_TYPE)) begin
          op_type <= i_rx.data;
        end
        if (rx_cnt == 16'(OFS_FLAGS)) begin
          no_reply <= i_rx.data[NO_REPLY_BIT];
        end
        if (rx_cnt == 16'(OFS_SHTL)) begin
          shtl_len <= i_rx.data[5:0] & ADDR_LEN_MASK;
        end
        if (rx_cnt == 16'(OFS_SSTL)) begin
          sstl_len <= i_rx.data[5:0] & ADDR_LEN_MASK;
        end
        if (rx_cnt == 16'(OFS_SRC_PLEN)) begin
          src_plen <= i_rx.data;
        end
      end
    end
  end

  // Only the first fault of a packet is kept, so one message at most.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      fault_seen <= 1'b0;
      fault_ofs <= WORD_RST;
    end else if (i_ce) begin
      if (back_to_recv) begin
        fault_seen <= 1'b0;
      end else if (fault_set) begin
        fault_seen <= 1'b1;
        fault_ofs <= rx_cnt;
      end
    end
  end

  // The sender's protocol address becomes the destination of the answer.
  generate
    for (genvar g = 0; g < 4; g++) begin : g_dst
      always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
          dst_byte[g] <= BYTE_RST;
        end else if (i_ce && dst_hit && dst_k[1:0] == 2'(g)) begin
          dst_byte[g] <= i_rx.data;
        end
      end
    end
  endgenerate

  assign dst_addr = {dst_byte[0], dst_byte[1], dst_byte[2], dst_byte[3]};

  // ****************************************************************
  // Error message content
  // ****************************************************************
  // An address longer than the field is omitted rather than cut short.
  assign err.code = ERR_AUTH_FAIL;
  assign err.offset = fault_ofs;
  assign err.dst_len = (src_plen <= PROTO_ADDR_LEN) ? src_plen :
                       8'h00;
  assign err.dst_addr = dst_addr;
  assign err.csum = csum;

  // ****************************************************************
  // Index, checksum and output register
  // ****************************************************************
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      idx <= BYTE_RST;
      acc <= WORD_RST;
      csum <= WORD_RST;
    end else if (i_ce) begin
      if (state == S_DECIDE) begin
        idx <= BYTE_RST;
        acc <= WORD_RST;
        csum <= WORD_RST;
      end else if (state == S_SUM_ADD) begin
        acc <= next_acc;
        idx <= is_last ? BYTE_RST : idx + 8'h01;
        if (is_last) begin
          csum <= ~next_acc;
        end
      end else if (state == S_HOLD && i_tx_ready) begin
        idx <= idx + 8'h01;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx <= '0;
    end else if (i_ce) begin
      if (state == S_LOAD) begin
        o_tx.valid <= 1'b1;
        o_tx.last <= is_last;
        o_tx.kind <= kind;
        o_tx.data <= load_byte;
      end else if (state == S_HOLD && i_tx_ready) begin
        o_tx.valid <= 1'b0;
      end
    end
  end

  // The faulty or oversized packet is simply never read out.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_purge <= 1'b0;
      o_drop <= 1'b0;
    end else if (i_ce) begin
      o_purge <= (state == S_DECIDE) & is_purge & ~too_long;
      o_drop <= (state == S_DECIDE) & (fault_seen | too_long);
    end
  end

  // ****************************************************************
  // Packet store and message generator
  // ****************************************************************
  prf_pkt_ram u_ram (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_we(rx_take & rx_fits),
    .i_waddr(rx_cnt[7:0]),
    .i_wdata(i_rx.data),
    .i_raddr(idx),
    .o_rdata(ram_q)
  );

  prf_err_gen u_gen (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_idx(idx),
    .i_cfg(i_cfg),
    .i_err(err),
    .o_byte(gen_q),
    .o_len(gen_len)
  );

endmodule

// ### prf_framer_asserts.sv
// Checker of the framer's outgoing message fields and decisions.
`timescale 1ns/1ps
module prf_framer_chk (
  // Clock, reset and enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Streams and identity
  input wire prf_pkg::prf_byte_s i_rx,
  input wire logic i_fault,
  input wire logic o_rx_ready,
  input wire prf_pkg::prf_cfg_s i_cfg,
  input wire prf_pkg::prf_tx_s o_tx,
  input wire logic i_tx_ready,
  // Events
  input wire logic o_purge,
  input wire logic o_drop
);
  import prf_pkg::*;
  logic [7:0] ti;
  logic [7:0] ri;
  logic [7:0] rt;
  logic es;
  logic rf;
  wire rx = i_ce && i_rx.valid && o_rx_ready;
  wire hs = i_ce && o_tx.valid && i_tx_ready;
  wire ev = o_tx.valid && o_tx.kind == PRF_KIND_ERR;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // ****
  // Byte indices, received type and fault, error already sent
  // ****
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ti <= 8'h00;
      ri <= 8'h00;
      rt <= 8'h00;
      es <= 1'b0;
      rf <= 1'b0;
    end else begin
      if (hs)
        ti <= o_tx.last ? 8'h00 : ti + 8'h01;
      if (rx)
        ri <= i_rx.last ? 8'h00 : ri + 8'h01;
      if (rx && ri == OFS_OP_TYPE)
        rt <= i_rx.data;
      if (rx)
        rf <= ((ri == 8'h00) ? 1'b0 : rf) | i_fault;
      // Cleared by the next packet, so one message per packet is enforced.
      if (rx)
        es <= 1'b0;
      else if (hs && ev && o_tx.last)
        es <= 1'b1;
    end
  end
  // ****
  // Assertions
  // ****
  reply_type_a: assert property (
    o_tx.valid && o_tx.kind == PRF_KIND_REPLY && ti == OFS_OP_TYPE
    |-> o_tx.data == OPT_PURGE_REPLY) else $error("reply type wrong");
  err_type_a: assert property (
    ev && ti == OFS_OP_TYPE |-> o_tx.data == OPT_ERR_IND)
    else $error("error type wrong");
  err_flags_a: assert property (
    ev && ti[7:1] == OFS_FLAGS[7:1] |-> o_tx.data == 8'h00)
    else $error("error flags not zero");
  err_code_a: assert property (
    ev && ti[7:1] == OFS_REQ_ID[7:1] |-> o_tx.data == (ti[0] ? 8'h0B : 8'h00))
    else $error("error code wrong");
  err_nbma_a: assert property (
    ev && ti == OFS_SHTL |-> o_tx.data == ATM_ADDR_LEN)
    else $error("source address length wrong");
  err_srclen_a: assert property (
    ev && ti == OFS_SRC_PLEN
    |-> o_tx.data == (i_cfg.src_proto_en ? PROTO_ADDR_LEN : 8'h00))
    else $error("source protocol length wrong");
  fault_drop_a: assert property (
    o_tx.valid && o_tx.kind != PRF_KIND_ERR |-> !rf)
    else $error("faulty packet passed on");
  drop_purge_a: assert property (
    o_drop |-> !o_purge) else $error("dropped packet purged");
  one_err_a: assert property (
    es |-> !ev) else $error("second error message");
  err_loop_a: assert property (
    ev |-> rt != OPT_ERR_IND) else $error("error answered error");
  purge_type_a: assert property (
    o_purge |-> rt == OPT_PURGE_REQ) else $error("purge on wrong type");
endmodule
bind prf_framer prf_framer_chk chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_ce(i_ce), .i_rx(i_rx), .i_fault(i_fault), .o_rx_ready(o_rx_ready),
  .i_cfg(i_cfg), .o_tx(o_tx), .i_tx_ready(i_tx_ready), .o_purge(o_purge),
  .o_drop(o_drop));

// ### prf_peer.sv
// Far-side peer that sinks outgoing messages, promptly or with stalls.
`timescale 1ns/1ps
module prf_peer (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Pace and message stream
  input wire logic i_slow,
  input wire prf_pkg::prf_tx_s i_tx,
  output logic o_ready
);
  import prf_pkg::*;
  logic [1:0] tick;
  logic [7:0] got [$];
  prf_kind_e kind;
  // Position, from one, of the first byte marked last in the message.
  int last_at;
  // A slow peer takes one cycle in four, so held bytes are exercised.
  assign o_ready = !i_slow || tick == 2'h0;
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tick <= 2'h0;
    end else begin
      tick <= tick + 2'h1;
      if (i_tx.valid && o_ready) begin
        got.push_back(i_tx.data);
        kind <= i_tx.kind;
        if (got.size() == 1)
          last_at <= i_tx.last ? 1 : 0;
        else if (i_tx.last && last_at == 0)
          last_at <= got.size();
      end
    end
  end
endmodule

// ### prf_framer_tb.sv
// Self-checking bench for the purge reply and error framer.
`timescale 1ns/1ps
`define CHK(a, b) begin \
  comparisons++; \
  if ((a) !== (b)) begin \
    num_errors++; \
    $display("unexpected at %0t got %h expected %h", $time, a, b); \
  end \
end
module prf_framer_tb;
  import prf_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic i_fault = 1'b0;
  logic i_slow = 1'b0;
  logic o_rx_ready;
  logic o_purge;
  logic o_drop;
  logic tx_ready;
  prf_byte_s i_rx = '0;
  prf_cfg_s i_cfg = '0;
  prf_tx_s o_tx;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] pkt [$];
  logic pu;
  logic dr;
  prf_framer uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_rx(i_rx), .i_fault(i_fault), .o_rx_ready(o_rx_ready),
    .i_cfg(i_cfg), .o_tx(o_tx), .i_tx_ready(tx_ready),
    .o_purge(o_purge), .o_drop(o_drop));
  prf_peer peer (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_slow(i_slow),
    .i_tx(o_tx), .o_ready(tx_ready));
  initial forever #4 i_sys_clk = ~i_sys_clk;
  // A hang is cut short well beyond the fewer than two thousand cycles needed.
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic mk(input int n, input logic [7:0] ty, input logic [7:0] fl,
                    input logic [7:0] sl);
    pkt.delete();
    for (int i = 0; i < n; i++)
      pkt.push_back(8'(i * 7 + 3));
    pkt[17] = ty;
    pkt[18] = 8'h00;
    pkt[19] = 8'h00;
    pkt[20] = sl;
    pkt[22] = fl;
  endtask
  // Sends pkt, flagging bytes f1 and f2, then waits until receive reopens.
  task automatic run(input int f1, input int f2);
    int k;
    logic t;
    peer.got.delete();
    pu = 1'b0;
    dr = 1'b0;
    k = 0;
    while (k < pkt.size()) begin
      i_rx = '{valid: 1'b1, last: k == pkt.size() - 1, data: pkt[k]};
      i_fault = (k == f1) || (k == f2);
      t = o_rx_ready;
      @(posedge i_sys_clk);
      #1;
      if (t)
        k++;
    end
    i_rx = '0;
    i_fault = 1'b0;
    for (int c = 0; c < 3000; c++) begin
      @(posedge i_sys_clk);
      #1;
      pu |= o_purge;
      dr |= o_drop;
      if (o_rx_ready)
        break;
    end
  endtask
  task automatic t_reply();
    i_slow = 1'b1;
    mk(40, OPT_PURGE_REQ, 8'h00, 8'h00);
    run(-1, -1);
    i_slow = 1'b0;
    `CHK(pu, 1'b1)
    `CHK(peer.got.size(), 40)
    `CHK(peer.kind, PRF_KIND_REPLY)
    `CHK(peer.last_at, 40)
    pkt[17] = OPT_PURGE_REPLY;
    for (int i = 0; i < 40; i++)
      `CHK(peer.got[i], pkt[i])
    $display("reply test done");
  endtask
  task automatic t_noreply();
    mk(24, OPT_PURGE_REQ, 8'h80, 8'h00);
    run(-1, -1);
    `CHK(pu, 1'b1)
    `CHK(peer.got.size(), 0)
    $display("no reply test done");
  endtask
  task automatic t_fwd();
    mk(30, 8'h01, 8'h00, 8'h00);
    run(-1, -1);
    `CHK(pu, 1'b0)
    `CHK(peer.kind, PRF_KIND_FWD)
    for (int i = 0; i < 30; i++)
      `CHK(peer.got[i], pkt[i])
    $display("forward test done");
  endtask
  task automatic t_err();
    logic [31:0] id;
    id = {ERR_AUTH_FAIL, 16'h001E};
    mk(40, OPT_PURGE_REQ, 8'h00, PROTO_ADDR_LEN);
    run(30, 35);
    `CHK(dr, 1'b1)
    `CHK(pu, 1'b0)
    `CHK(peer.kind, PRF_KIND_ERR)
    `CHK(peer.got.size(), 56)
    `CHK(peer.last_at, 56)
    `CHK(peer.got[11], 8'h38)
    `CHK(peer.got[17], OPT_ERR_IND)
    `CHK(peer.got[19], 8'h00)
    `CHK(peer.got[21], PROTO_ADDR_LEN)
    `CHK(peer.got[23], 8'h00)
    for (int i = 0; i < 4; i++)
      `CHK(peer.got[24 + i], id[31 - 8 * i -: 8])
    for (int i = 0; i < 20; i++)
      `CHK(peer.got[28 + i], i_cfg.atm_addr[159 - 8 * i -: 8])
    for (int i = 0; i < 4; i++)
      `CHK(peer.got[48 + i], i_cfg.src_proto[31 - 8 * i -: 8])
    for (int i = 0; i < 4; i++)
      `CHK(peer.got[52 + i], pkt[28 + i])
    $display("error test done");
  endtask
  // Fault on the very first octet, with a subaddress and no protocol address.
  task automatic t_err2();
    i_cfg.src_proto_en = 1'b0;
    i_cfg.sub_en = 1'b1;
    mk(30, 8'h01, 8'h00, 8'h00);
    run(0, -1);
    `CHK(dr, 1'b1)
    `CHK(peer.got.size(), 68)
    `CHK(peer.got[19], ATM_ADDR_LEN)
    `CHK(peer.got[20], 8'h00)
    `CHK(peer.got[21], 8'h00)
    `CHK(peer.got[27], 8'h00)
    for (int i = 0; i < 20; i++)
      `CHK(peer.got[48 + i], i_cfg.sub_addr[159 - 8 * i -: 8])
    $display("second error test done");
  endtask
  task automatic t_errerr();
    mk(30, OPT_ERR_IND, 8'h00, 8'h00);
    run(20, -1);
    `CHK(dr, 1'b1)
    `CHK(peer.got.size(), 0)
    $display("error on error test done");
  endtask
  // A purge request too long for the store is dropped and never answered.
  task automatic t_long();
    mk(260, OPT_PURGE_REQ, 8'h00, 8'h00);
    run(-1, -1);
    `CHK(dr, 1'b1)
    `CHK(pu, 1'b0)
    `CHK(peer.got.size(), 0)
    $display("long packet test done");
  endtask
  initial begin
    i_cfg.atm_addr = {5{32'h4792_0183}};
    i_cfg.sub_addr = {5{32'hC3D4_E5F6}};
    i_cfg.src_proto = 32'h0A00_0001;
    i_cfg.src_proto_en = 1'b1;
    repeat (5) @(posedge i_sys_clk);
    #1;
    i_rst = 1'b0;
    t_reply();
    t_noreply();
    t_err();
    t_fwd();
    t_err2();
    t_errerr();
    t_long();
    t_reply();
    finish_test();
  end
endmodule
